// file: hw/gpio_wakeup_controller.sv
/*
  GPIO wake-up controller: per-line polarity, a debounced button path
  and a latched edge path, with a classic Wishbone register slave.
  Assumes gpio_i is asynchronous to clk_i, which stands for the sleep
  clock; the bus master follows classic single cycles.
*/
// The Wishbone register port and the register offsets were chosen for this implementation.
// What this block does
// - Wakes from clocked sleep, and requests the clock in clockless mode.
// - Synchronises lines; a level counts after three equal clock samples.
// - Watches all 37 lines, each through a polarity XOR.
// - Per-line polarity comes from software-written polarity registers.
// - Debounced button path, lines chosen by debounce select registers.
// - Debounce time programmable from 0 to 63 milliseconds.
// - Counter loads, counts down per ms; fires if lines still active.
// - Edge-selected lines latch active edges as pending status bits.
// - Wake interrupt includes the OR of all pending edge status bits.
// - Enable bit masks the wake interrupt; cleared edge select excludes.
// - Any write to the interrupt clear register clears the pending debounce wake.
// - Writing edge status clear registers clears the selected bits.
// - Edge latching is disabled while in clockless sleep mode.
// - Wake interrupt goes out to the wake interrupt controller.
module gpio_wakeup_controller #(
  parameter int DEB_TICK_CYC = wake_pkg::DEB_TICK_CYC
) (
  input  wire logic        clk_i,      // Sleep clock, 125 MHz
  input  wire logic        rst_i,      // Synchronous reset, high
  input  wire logic [36:0] gpio_i,     // Monitored GPIO levels
  input  wire logic        wb_cyc_i,   // Wishbone cycle
  input  wire logic        wb_stb_i,   // Wishbone strobe
  input  wire logic        wb_we_i,    // Wishbone write enable
  input  wire logic [7:0]  wb_adr_i,   // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,   // Wishbone byte selects
  input  wire logic [31:0] wb_dat_i,   // Wishbone write data
  output logic      [31:0] wb_dat_o,   // Wishbone read data
  output logic             wb_ack_o,   // Wishbone acknowledge
  output logic             wake_irq_o, // To wake interrupt controller
  output logic             int_o,      // Masked event interrupt
  output logic             clk_req_o   // Clock start request
);

  localparam logic [wake_pkg::TICK_W-1:0] TICK_LAST =
    wake_pkg::TICK_W'(DEB_TICK_CYC - 1);

  wake_pkg::state_t s;
  wake_pkg::state_t n;

  logic [36:0] stable_nxt;
  logic [36:0] active;
  logic [36:0] edge_hit;
  logic [36:0] clr_mask;
  logic [31:0] bmask;
  logic        req;
  logic        wr;
  logic        deb_or;
  logic        deb_fire;
  logic        irq_clr;
  logic        ist_rd;

  // ----------------------------------------------------------------
  // Per-line stability filter
  // ----------------------------------------------------------------
  // A bit moves only after three equal post-synchroniser samples,
  // which rejects glitches shorter than three clock pulses.
  for (genvar i = 0; i < wake_pkg::NUM_LINES; i++)
  begin : g_line
    assign stable_nxt[i] =
      ((s.sync2[i] == s.hist1[i]) && (s.hist1[i] == s.hist2[i]))
      ? s.sync2[i]
      : s.stable[i];
  end

  assign active   = s.stable ^ s.pol;
  assign deb_or   = |(active & s.deb_sel);
  assign edge_hit = active & ~s.act_prev & s.edge_sel
                  & {wake_pkg::NUM_LINES{~s.clockless}};

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign req   = wb_cyc_i & wb_stb_i & ~s.ack;
  assign wr    = req & wb_we_i;
  assign bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign irq_clr = wr && (wb_adr_i == wake_pkg::OFS_IRQ_CLR);
  assign ist_rd  = req && !wb_we_i && (wb_adr_i == wake_pkg::OFS_INT_STAT);

  always_comb
  begin
    clr_mask = '0;
    if (wr && (wb_adr_i == wake_pkg::OFS_CLR_LO))
      clr_mask[31:0] = wb_dat_i & bmask;
    if (wr && (wb_adr_i == wake_pkg::OFS_CLR_HI))
      clr_mask[36:32] = wb_dat_i[4:0] & bmask[4:0];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    n          = s;
    deb_fire   = 1'b0;
    n.sync1    = gpio_i;
    n.sync2    = s.sync1;
    n.hist1    = s.sync2;
    n.hist2    = s.hist1;
    n.stable   = stable_nxt;
    n.act_prev = active;

    // Millisecond tick
    n.tick = 1'b0;
    if (s.tick_cnt == TICK_LAST)
    begin
      n.tick_cnt = '0;
      n.tick     = 1'b1;
    end
    else
      n.tick_cnt = s.tick_cnt + 1'b1;

    // Debounce sequencer
    unique case (s.dstate)
      wake_pkg::DEB_IDLE:
      begin
        if (deb_or)
        begin
          n.deb_cnt = s.deb_value;
          n.dstate  = wake_pkg::DEB_COUNT;
        end
      end
      wake_pkg::DEB_COUNT:
      begin
        if (s.tick)
        begin
          if (s.deb_cnt == '0)
          begin
            deb_fire = deb_or;
            n.dstate = deb_or ? wake_pkg::DEB_HOLD : wake_pkg::DEB_IDLE;
          end
          else
            n.deb_cnt = s.deb_cnt - 1'b1;
        end
      end
      wake_pkg::DEB_HOLD:
      begin
        // One interrupt per press; wait for release before rearming
        if (!deb_or)
          n.dstate = wake_pkg::DEB_IDLE;
      end
      default:
        n.dstate = wake_pkg::DEB_IDLE;
    endcase

    // Pending flags: a new event wins over a clear in the same cycle
    n.deb_pend = deb_fire | (s.deb_pend & ~irq_clr);
    n.status   = edge_hit | (s.status & ~clr_mask);
    n.ist      = {|edge_hit, deb_fire} | (ist_rd ? 2'b00 : s.ist);

    // Register writes
    if (wr)
    begin
      unique case (wb_adr_i)
        wake_pkg::OFS_CTRL:
        begin
          if (wb_sel_i[0])
          begin
            n.deb_value = wb_dat_i[wake_pkg::CTRL_DEB_LSB +: 6];
            n.irq_en    = wb_dat_i[wake_pkg::CTRL_IRQ_EN];
            n.clockless = wb_dat_i[wake_pkg::CTRL_CLKLESS];
          end
        end
        wake_pkg::OFS_POL_LO:
          n.pol[31:0] = (s.pol[31:0] & ~bmask) | (wb_dat_i & bmask);
        wake_pkg::OFS_POL_HI:
          if (wb_sel_i[0])
            n.pol[36:32] = wb_dat_i[4:0];
        wake_pkg::OFS_DSEL_LO:
          n.deb_sel[31:0] = (s.deb_sel[31:0] & ~bmask) | (wb_dat_i & bmask);
        wake_pkg::OFS_DSEL_HI:
          if (wb_sel_i[0])
            n.deb_sel[36:32] = wb_dat_i[4:0];
        wake_pkg::OFS_ESEL_LO:
          n.edge_sel[31:0] = (s.edge_sel[31:0] & ~bmask)
                           | (wb_dat_i & bmask);
        wake_pkg::OFS_ESEL_HI:
          if (wb_sel_i[0])
            n.edge_sel[36:32] = wb_dat_i[4:0];
        wake_pkg::OFS_INT_MASK:
          if (wb_sel_i[0])
            n.imask = wb_dat_i[1:0];
        default:
          n.imask = s.imask;
      endcase
    end

    // Read data and acknowledge; unmapped reads answer zero
    n.ack   = req;
    n.rdata = '0;
    if (req && !wb_we_i)
    begin
      unique case (wb_adr_i)
        wake_pkg::OFS_CTRL:
          n.rdata = {24'h0, s.clockless, s.irq_en, s.deb_value};
        wake_pkg::OFS_POL_LO:   n.rdata = s.pol[31:0];
        wake_pkg::OFS_POL_HI:   n.rdata = {27'h0, s.pol[36:32]};
        wake_pkg::OFS_DSEL_LO:  n.rdata = s.deb_sel[31:0];
        wake_pkg::OFS_DSEL_HI:  n.rdata = {27'h0, s.deb_sel[36:32]};
        wake_pkg::OFS_ESEL_LO:  n.rdata = s.edge_sel[31:0];
        wake_pkg::OFS_ESEL_HI:  n.rdata = {27'h0, s.edge_sel[36:32]};
        wake_pkg::OFS_STAT_LO:  n.rdata = s.status[31:0];
        wake_pkg::OFS_STAT_HI:  n.rdata = {27'h0, s.status[36:32]};
        wake_pkg::OFS_INT_STAT: n.rdata = {30'h0, s.ist};
        wake_pkg::OFS_INT_MASK: n.rdata = {30'h0, s.imask};
        default:                n.rdata = 32'h0;
      endcase
    end

    // Outputs
    n.wake_irq  = s.irq_en & (s.deb_pend | (|s.status));
    n.int_irq   = |(s.ist & s.imask);
    // In clockless mode a raw active line selected for debounce or edge asks the power logic for a clock
    n.clk_start = s.clockless & (|((s.sync2 ^ s.pol)
                                  & (s.deb_sel | s.edge_sel)));
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s <= '0;
    else
      s <= n;
  end

  assign wb_dat_o   = s.rdata;
  assign wb_ack_o   = s.ack;
  assign wake_irq_o = s.wake_irq;
  assign int_o      = s.int_irq;
  assign clk_req_o  = s.clk_start;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence deb_armed;
    (s.dstate == wake_pkg::DEB_IDLE) && deb_or;
  endsequence

  sequence deb_expire;
    (s.dstate == wake_pkg::DEB_COUNT) && s.tick && (s.deb_cnt == '0);
  endsequence

  chk_stable_three: assert property (
    (s.stable[0] != $past(s.stable[0])) |->
      (s.stable[0] == $past(s.sync2[0])) &&
      ($past(s.sync2[0]) == $past(s.sync2[0], 2)) &&
      ($past(s.sync2[0]) == $past(s.sync2[0], 3)))
    else $error("stable line moved without three equal samples");

  chk_deb_load: assert property (
    deb_armed |=> (s.dstate == wake_pkg::DEB_COUNT) &&
                  (s.deb_cnt == $past(s.deb_value)))
    else $error("debounce counter not loaded");

  chk_deb_fire: assert property (
    deb_expire ##0 deb_or |=>
      s.deb_pend ##1 (s.wake_irq == $past(s.irq_en)))
    else $error("debounce expiry did not raise wake");

  chk_ms_tick: assert property (
    s.tick |-> ($past(s.tick_cnt) == TICK_LAST) && (s.tick_cnt == '0))
    else $error("tick not spaced by one millisecond");

  chk_edge_latch: assert property (
    (|edge_hit) |=> ((s.status & $past(edge_hit)) == $past(edge_hit)))
    else $error("active edge not latched");

  chk_clockless_hold: assert property (
    s.clockless && !(|clr_mask) |=> (s.status == $past(s.status)))
    else $error("edge latched in clockless mode");

  chk_wake_mask: assert property (
    !s.irq_en && !wr |=> !s.wake_irq)
    else $error("wake raised while masked");

  chk_wake_or: assert property (
    s.irq_en && (|s.status) && !wr |=> s.wake_irq)
    else $error("pending edge did not raise wake");

  chk_irq_clear: assert property (
    irq_clr && !deb_fire |=> !s.deb_pend)
    else $error("wake clear write ignored");

  chk_status_clear: assert property (
    (|clr_mask) && !(|edge_hit) |=> ((s.status & $past(clr_mask)) == '0))
    else $error("status clear write ignored");

  chk_ack_pulse: assert property (
    s.ack |=> !s.ack)
    else $error("ack held longer than one cycle");

endmodule

// file: hw/wake_pkg.sv
/*
  Shared constants and types for the GPIO wake-up controller.
  Assumes a single 125 MHz clock and a 32-bit classic Wishbone master.
*/
package wake_pkg;

  // ----------------------------------------------------------------
  // Geometry and timing
  // ----------------------------------------------------------------
  localparam int          NUM_LINES     = 37;
  localparam int          HI_LINES      = NUM_LINES - 32;
  localparam int          DEB_W         = 6;
  localparam int          STABLE_PULSES = 3;
  localparam int          CLK_PERIOD_NS = 8;
  localparam int          DEB_TICK_NS   = 1000000;
  localparam int          DEB_TICK_CYC  = DEB_TICK_NS / CLK_PERIOD_NS;
  localparam int          TICK_W        = 20;

  // ----------------------------------------------------------------
  // Register word offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_POL_LO    = 8'h04;
  localparam logic [7:0]  OFS_POL_HI    = 8'h08;
  localparam logic [7:0]  OFS_DSEL_LO   = 8'h0c;
  localparam logic [7:0]  OFS_DSEL_HI   = 8'h10;
  localparam logic [7:0]  OFS_ESEL_LO   = 8'h14;
  localparam logic [7:0]  OFS_ESEL_HI   = 8'h18;
  localparam logic [7:0]  OFS_STAT_LO   = 8'h1c;
  localparam logic [7:0]  OFS_STAT_HI   = 8'h20;
  localparam logic [7:0]  OFS_CLR_LO    = 8'h24;
  localparam logic [7:0]  OFS_CLR_HI    = 8'h28;
  localparam logic [7:0]  OFS_IRQ_CLR   = 8'h2c;
  localparam logic [7:0]  OFS_INT_STAT  = 8'h30;
  localparam logic [7:0]  OFS_INT_MASK  = 8'h34;

  // Control word field positions
  localparam int          CTRL_DEB_LSB  = 0;
  localparam int          CTRL_IRQ_EN   = 6;
  localparam int          CTRL_CLKLESS  = 7;

  // Event status bits
  localparam int          EV_DEB        = 0;
  localparam int          EV_EDGE       = 1;

  // Reset values
  localparam logic [NUM_LINES-1:0] LINES_RST = 37'h0;
  localparam logic [DEB_W-1:0]     DEB_RST   = 6'h00;

  // Debounce sequencer, Gray coded along idle -> count -> hold
  typedef enum logic [1:0] {
    DEB_IDLE  = 2'b00,
    DEB_COUNT = 2'b01,
    DEB_HOLD  = 2'b11
  } deb_state_t;

  typedef struct packed {
    logic [NUM_LINES-1:0] sync1;
    logic [NUM_LINES-1:0] sync2;
    logic [NUM_LINES-1:0] hist1;
    logic [NUM_LINES-1:0] hist2;
    logic [NUM_LINES-1:0] stable;
    logic [NUM_LINES-1:0] act_prev;
    logic [NUM_LINES-1:0] pol;
    logic [NUM_LINES-1:0] deb_sel;
    logic [NUM_LINES-1:0] edge_sel;
    logic [NUM_LINES-1:0] status;
    logic [DEB_W-1:0]     deb_value;
    logic                 irq_en;
    logic                 clockless;
    deb_state_t           dstate;
    logic [DEB_W-1:0]     deb_cnt;
    logic [TICK_W-1:0]    tick_cnt;
    logic                 tick;
    logic                 deb_pend;
    logic [1:0]           ist;
    logic [1:0]           imask;
    logic                 ack;
    logic [31:0]          rdata;
    logic                 wake_irq;
    logic                 int_irq;
    logic                 clk_start;
  } state_t;

endpackage

// file: tb/gpio_source.sv
/*
  Model of the buttons and sensors that drive the GPIO lines.
  Assumes the bench calls its tasks; levels change at rising edges.
*/
module gpio_source (
  input  wire logic        clk_i,  // Bench clock
  output logic      [36:0] gpio_o  // Line levels
);
  timeunit 1ns;
  timeprecision 1ps;
  initial gpio_o = 37'h0;
  task automatic set_line(input int idx, input logic val);
    @(posedge clk_i);
    gpio_o[idx] <= val;
  endtask
  // Widths under three clocks are only ever asked for on purpose
  task automatic pulse(input int idx, input int width);
    set_line(idx, 1'b1);
    repeat (width) @(posedge clk_i);
    gpio_o[idx] <= 1'b0;
  endtask
endmodule

// file: tb/gpio_wakeup_controller_tb.sv
/*
  Bench for the GPIO wake-up controller: Wishbone tasks and sequences.
  Assumes a shortened millisecond tick of TICK clocks.
*/
module gpio_wakeup_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 20;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        wake;
  logic        irq;
  logic        creq;
  logic [36:0] gpio;
  logic [31:0] rd;
  int          fail_count = 0;
  int          n_compared = 0;

  always #4 clk_i = ~clk_i;

  gpio_source gpio_source_i (.clk_i(clk_i), .gpio_o(gpio));
  gpio_wakeup_controller #(.DEB_TICK_CYC(TICK)) gpio_wakeup_controller_i (
    .clk_i(clk_i), .rst_i(rst_i), .gpio_i(gpio), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wake_irq_o(wake), .int_o(irq), .clk_req_o(creq));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hf;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1)
    begin
      fail_count++;
      conclude();
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rdc(input string what, input logic [7:0] a,
                     input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(what, rd, e);
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Time from press to wake must sit between the loaded count of ticks and one tick more, plus 12 clocks
  task automatic deb_run(input logic [5:0] v);
    int c;
    wr(wake_pkg::OFS_CTRL, {24'h0, 2'b01, v});
    wr(wake_pkg::OFS_IRQ_CLR, 32'h0);
    gpio_source_i.set_line(0, 1'b1);
    c = 0;
    while (wake !== 1'b1 && c < 2000)
    begin
      @(posedge clk_i);
      c++;
    end
    if (wake !== 1'b1)
    begin
      fail_count++;
      conclude();
    end
    chk("deb_time", c >= v*TICK && c <= (v+1)*TICK+12, 1);
    chk("int_o", irq, 1);
    rdc("ev_stat", wake_pkg::OFS_INT_STAT, 32'h1);
    gap(2);
    chk("int_o clr", irq, 0);
    gpio_source_i.set_line(0, 1'b0);
    gap(10);
    wr(wake_pkg::OFS_IRQ_CLR, 32'h0);
    gap(2);
    chk("wake clr", wake, 0);
    $display("test debounce %0d done", v);
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    gap(6);
    rst_i <= 1'b0;
    for (int a = 0; a < 64; a += 4)
      rdc("reset", a[7:0], 32'h0);
    wr(8'h38, 32'hffffffff);
    rdc("unmapped", 8'h38, 32'h0);
    wr(wake_pkg::OFS_POL_LO, 32'ha5a5a5a5);
    rdc("pol_lo", wake_pkg::OFS_POL_LO, 32'ha5a5a5a5);
    wr(wake_pkg::OFS_POL_LO, 32'h0);
    wr(wake_pkg::OFS_POL_HI, 32'h1f);
    rdc("pol_hi", wake_pkg::OFS_POL_HI, 32'h1f);
    wr(wake_pkg::OFS_POL_HI, 32'h0);
    wr(wake_pkg::OFS_DSEL_HI, 32'h15);
    rdc("dsel_hi", wake_pkg::OFS_DSEL_HI, 32'h15);
    wr(wake_pkg::OFS_DSEL_HI, 32'h0);
    $display("test registers done");
    wr(wake_pkg::OFS_CTRL, 32'h40);
    wr(wake_pkg::OFS_ESEL_LO, 32'h8);
    wr(wake_pkg::OFS_ESEL_HI, 32'h10);
    gpio_source_i.set_line(3, 1'b1);
    gpio_source_i.set_line(36, 1'b1);
    gap(12);
    rdc("stat_lo", wake_pkg::OFS_STAT_LO, 32'h8);
    rdc("stat_hi", wake_pkg::OFS_STAT_HI, 32'h10);
    rdc("ev edge", wake_pkg::OFS_INT_STAT, 32'h2);
    chk("wake", wake, 1);
    wr(wake_pkg::OFS_CLR_LO, 32'h8);
    rdc("clr_lo", wake_pkg::OFS_STAT_LO, 32'h0);
    chk("wake hi", wake, 1);
    wr(wake_pkg::OFS_CTRL, 32'h0);
    gap(2);
    chk("wake off", wake, 0);
    wr(wake_pkg::OFS_CTRL, 32'h40);
    wr(wake_pkg::OFS_CLR_HI, 32'h10);
    gap(2);
    chk("wake clr", wake, 0);
    gpio_source_i.set_line(3, 1'b0);
    gpio_source_i.set_line(36, 1'b0);
    gpio_source_i.set_line(5, 1'b1);
    gap(10);
    wr(wake_pkg::OFS_POL_LO, 32'h20);
    wr(wake_pkg::OFS_ESEL_LO, 32'h20);
    gap(10);
    rdc("pol idle", wake_pkg::OFS_STAT_LO, 32'h0);
    gpio_source_i.set_line(5, 1'b0);
    gap(12);
    rdc("pol edge", wake_pkg::OFS_STAT_LO, 32'h20);
    wr(wake_pkg::OFS_CLR_LO, 32'h20);
    wr(wake_pkg::OFS_ESEL_LO, 32'h0);
    gpio_source_i.pulse(7, 6);
    gap(12);
    rdc("unselected", wake_pkg::OFS_STAT_LO, 32'h0);
    wr(wake_pkg::OFS_ESEL_LO, 32'h3);
    gpio_source_i.pulse(0, 2);
    gap(12);
    rdc("glitch", wake_pkg::OFS_STAT_LO, 32'h0);
    gpio_source_i.pulse(1, 3);
    gap(12);
    rdc("three", wake_pkg::OFS_STAT_LO, 32'h2);
    wr(wake_pkg::OFS_CLR_LO, 32'h2);
    $display("test edge path done");
    wr(wake_pkg::OFS_CTRL, 32'hc0);
    wr(wake_pkg::OFS_ESEL_LO, 32'h10);
    gpio_source_i.set_line(4, 1'b1);
    gap(12);
    chk("clk_req", creq, 1);
    rdc("clockless", wake_pkg::OFS_STAT_LO, 32'h0);
    chk("wake cl", wake, 0);
    gpio_source_i.set_line(4, 1'b0);
    gap(12);
    chk("clk_req off", creq, 0);
    wr(wake_pkg::OFS_CTRL, 32'h40);
    wr(wake_pkg::OFS_ESEL_LO, 32'h0);
    $display("test clockless done");
    wr(wake_pkg::OFS_DSEL_LO, 32'h1);
    wr(wake_pkg::OFS_INT_MASK, 32'h1);
    wb(1'b0, wake_pkg::OFS_INT_STAT, 32'h0);
    deb_run(6'h00);
    deb_run(6'h02);
    deb_run(6'h3f);
    wr(wake_pkg::OFS_CTRL, 32'h42);
    gpio_source_i.pulse(0, 12);
    gap(4*TICK);
    chk("early release", wake, 0);
    $display("test debounce release done");
    conclude();
  end
endmodule
